// ### logic/mwm_pkg.sv
// Package for the maintenance warning monitor: register map, layouts, defaults
package mwm_pkg;
  // Condition indices
  localparam int unsigned NCOND = 8;
  localparam int unsigned C_USR = 0;
  localparam int unsigned C_POS = 1;
  localparam int unsigned C_DRV = 2;
  localparam int unsigned C_MTR = 3;
  localparam int unsigned C_OV = 4;
  localparam int unsigned C_UV = 5;
  localparam int unsigned C_TLC = 6;
  localparam int unsigned C_SPD = 7;
  // Register byte offsets
  localparam logic [7:0] A_FLAGS = 8'h00;
  localparam logic [7:0] A_CTRL = 8'h04;
  localparam logic [7:0] A_ACTION = 8'h08;
  localparam logic [7:0] A_USRSEL = 8'h0C;
  localparam logic [7:0] A_CLEAR = 8'h10;
  localparam logic [7:0] A_IRQST = 8'h14;
  localparam logic [7:0] A_IRQMSK = 8'h18;
  localparam logic [7:0] A_TH_POS = 8'h20;
  localparam logic [7:0] A_TH_DRV = 8'h24;
  localparam logic [7:0] A_TH_MTR = 8'h28;
  localparam logic [7:0] A_TH_OV = 8'h2C;
  localparam logic [7:0] A_TH_UV = 8'h30;
  localparam logic [7:0] A_TH_TLC = 8'h34;
  localparam logic [7:0] A_TH_SPD = 8'h38;
  // Field positions in CTRL
  localparam int unsigned B_AUTOCLR = 0;
  localparam int unsigned B_LEDEN = 1;
  localparam int unsigned B_USRINV = 8;
  // Reset values
  localparam logic [15:0] R_TH_POS = 16'd300;
  localparam logic [15:0] R_TH_DRV = 16'd85;
  localparam logic [15:0] R_TH_MTR = 16'd85;
  localparam logic [15:0] R_TH_OV = 16'd400;
  localparam logic [15:0] R_TH_UV = 16'd120;
  localparam logic [15:0] R_TH_TLC = 16'd0;
  localparam logic [15:0] R_TH_SPD = 16'd0;
  localparam logic [7:0] R_USRSEL = 8'd128;
  localparam logic [7:0] R_ACTION = 8'hFF;
  // LED timing: 2 blinks, 200 ms on and off
  localparam int unsigned BLINK_COUNT = 2;
  localparam int unsigned BLINK_MS = 200;
  localparam int unsigned CLK_KHZ = 10000;
  localparam int unsigned BLINK_CYC = BLINK_MS * CLK_KHZ;
  // Measured quantities from the servo core
  typedef struct packed {
    logic [15:0] pos_dev;
    logic [15:0] drv_temp;
    logic [15:0] mtr_temp;
    logic [15:0] bus_volt;
    logic [15:0] tlc_ms;
    logic [15:0] speed;
  } mwm_meas_t;
  // LED drive pair
  typedef struct packed {
    logic red;
    logic green;
  } mwm_led_t;
endpackage : mwm_pkg

// ### logic/mwm_compare.sv
// Threshold comparator bank producing raw warning causes
`timescale 1ns/100ps
`default_nettype none
module mwm_compare (
  // Measurements and thresholds
  input wire mwm_pkg::mwm_meas_t meas,
  input wire logic [15:0] th_pos,
  input wire logic [15:0] th_drv,
  input wire logic [15:0] th_mtr,
  input wire logic [15:0] th_ov,
  input wire logic [15:0] th_uv,
  input wire logic [15:0] th_tlc,
  input wire logic [15:0] th_spd,
  // Raw causes, one per threshold condition
  output logic [mwm_pkg::NCOND-1:1] cause
);
  always_comb begin
    cause[mwm_pkg::C_POS] = meas.pos_dev > th_pos;
    cause[mwm_pkg::C_DRV] = meas.drv_temp >= th_drv;
    cause[mwm_pkg::C_MTR] = meas.mtr_temp >= th_mtr;
    cause[mwm_pkg::C_OV] = meas.bus_volt >= th_ov;
    cause[mwm_pkg::C_UV] = meas.bus_volt <= th_uv;
    // Zero threshold disables the check
    cause[mwm_pkg::C_TLC] = (th_tlc != 16'h0000) && (meas.tlc_ms >= th_tlc);
    cause[mwm_pkg::C_SPD] = (th_spd != 16'h0000) && (meas.speed >= th_spd);
  end
endmodule : mwm_compare
`default_nettype wire

// ### logic/mwm_led.sv
// Double blink sequencer for the power/alarm LED
`timescale 1ns/100ps
`default_nettype none
module mwm_led #(
  parameter int unsigned PHASE_CYC = mwm_pkg::BLINK_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Trigger pulse
  input wire logic start,
  // LED drive
  output var mwm_pkg::mwm_led_t led,
  output logic busy
);
  logic [31:0] cnt;
  logic [2:0] phase;
  assign busy = phase != 3'd0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 32'h00000000;
      phase <= 3'd0;
    end else if (phase == 3'd0) begin
      if (start) begin
        phase <= 3'd1;
        cnt <= 32'h00000000;
      end
    end else if (cnt == PHASE_CYC - 1) begin
      cnt <= 32'h00000000;
      phase <= (phase == 3'(2 * mwm_pkg::BLINK_COUNT)) ? 3'd0 : phase + 3'd1;
    end else begin
      cnt <= cnt + 32'h00000001;
    end
  end
  // Odd phases lit: red and green together
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      led <= '0;
    end else begin
      led.red <= phase[0];
      led.green <= phase[0];
    end
  end
endmodule : mwm_led
`default_nettype wire

// ### logic/mwm_top.sv
// Maintenance warning monitor with AHB-Lite register access
// Functional notes
// - Each detected condition sets its own flag bit.
// - User flag follows the configured internal signal.
// - Summary output rises on any summary-enabled condition.
// - Enabled warning blinks red and green together twice.
// - Warnings never stop the motor; no drive inhibit exists.
// - Action 0 sets only the flag, no summary or LED; the code still sets the interrupt status bit on the rising cause.
// - Auto-clear 1 drops flag and summary when cause ends.
// - Global LED enable gates blinking, default on.
// - Selection picks the user source; code 128 is constant off.
// - Inversion bit inverts the selected source when 1.
// - Position deviation warning above threshold, default 300.
// - Temperature, voltage, torque time and speed compared; zero disables torque time and speed.
// - Warnings are level checks raised before any alarm.
//
// Implementation choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module mwm_top #(
  parameter int unsigned SRC_W = 128,
  parameter int unsigned BLINK_CYC = mwm_pkg::BLINK_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Servo core quantities and signals
  input wire mwm_pkg::mwm_meas_t meas,
  input wire logic [SRC_W-1:0] usr_src,
  // Warning outputs
  output logic [mwm_pkg::NCOND-1:0] per_condition_warning_flag,
  output logic warning_summary_output,
  output var mwm_pkg::mwm_led_t power_alarm_led,
  output logic irq
);
  localparam int unsigned N = mwm_pkg::NCOND;
  // Registers
  logic [15:0] th_pos, th_drv, th_mtr, th_ov, th_uv, th_tlc, th_spd;
  logic auto_clr, led_en, usr_inv;
  logic [7:0] usr_sel, action;
  logic [N-1:0] irq_st, irq_msk;
  logic [N-1:0] flags;
  logic summary;
  // Bus pipeline
  logic wr_pend;
  logic [7:0] wr_addr;
  logic clr_cmd;
  logic [N-1:0] cause, cause_q, rise;
  logic [N-1:1] cmp_cause;
  logic user_selected_warning_flag;
  logic blink_start;
  logic led_busy;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = a == r;
  endfunction : hit

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  wire addr_ok = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= addr_ok && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // Read data registered in address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_ok && !hwrite) begin
      unique case (haddr[7:0])
        mwm_pkg::A_FLAGS: hrdata <= {23'h0, summary, flags};
        mwm_pkg::A_CTRL: hrdata <= {23'h0, usr_inv, 6'h0, led_en, auto_clr};
        mwm_pkg::A_ACTION: hrdata <= {24'h0, action};
        mwm_pkg::A_USRSEL: hrdata <= {24'h0, usr_sel};
        mwm_pkg::A_IRQST: hrdata <= {24'h0, irq_st};
        mwm_pkg::A_IRQMSK: hrdata <= {24'h0, irq_msk};
        mwm_pkg::A_TH_POS: hrdata <= {16'h0, th_pos};
        mwm_pkg::A_TH_DRV: hrdata <= {16'h0, th_drv};
        mwm_pkg::A_TH_MTR: hrdata <= {16'h0, th_mtr};
        mwm_pkg::A_TH_OV: hrdata <= {16'h0, th_ov};
        mwm_pkg::A_TH_UV: hrdata <= {16'h0, th_uv};
        mwm_pkg::A_TH_TLC: hrdata <= {16'h0, th_tlc};
        mwm_pkg::A_TH_SPD: hrdata <= {16'h0, th_spd};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // Configuration writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      th_pos <= mwm_pkg::R_TH_POS;
      th_drv <= mwm_pkg::R_TH_DRV;
      th_mtr <= mwm_pkg::R_TH_MTR;
      th_ov <= mwm_pkg::R_TH_OV;
      th_uv <= mwm_pkg::R_TH_UV;
      th_tlc <= mwm_pkg::R_TH_TLC;
      th_spd <= mwm_pkg::R_TH_SPD;
      auto_clr <= 1'b1;
      led_en <= 1'b1;
      usr_inv <= 1'b0;
      usr_sel <= mwm_pkg::R_USRSEL;
      action <= mwm_pkg::R_ACTION;
      irq_msk <= '0;
    end else if (wr_pend) begin
      if (hit(wr_addr, mwm_pkg::A_TH_POS)) th_pos <= hwdata[15:0];
      if (hit(wr_addr, mwm_pkg::A_TH_DRV)) th_drv <= hwdata[15:0];
      if (hit(wr_addr, mwm_pkg::A_TH_MTR)) th_mtr <= hwdata[15:0];
      if (hit(wr_addr, mwm_pkg::A_TH_OV)) th_ov <= hwdata[15:0];
      if (hit(wr_addr, mwm_pkg::A_TH_UV)) th_uv <= hwdata[15:0];
      if (hit(wr_addr, mwm_pkg::A_TH_TLC)) th_tlc <= hwdata[15:0];
      if (hit(wr_addr, mwm_pkg::A_TH_SPD)) th_spd <= hwdata[15:0];
      if (hit(wr_addr, mwm_pkg::A_CTRL)) begin
        auto_clr <= hwdata[mwm_pkg::B_AUTOCLR];
        led_en <= hwdata[mwm_pkg::B_LEDEN];
        usr_inv <= hwdata[mwm_pkg::B_USRINV];
      end
      if (hit(wr_addr, mwm_pkg::A_ACTION)) action <= hwdata[7:0];
      if (hit(wr_addr, mwm_pkg::A_USRSEL)) usr_sel <= hwdata[7:0];
      if (hit(wr_addr, mwm_pkg::A_IRQMSK)) irq_msk <= hwdata[N-1:0];
    end
  end

  assign clr_cmd = wr_pend && hit(wr_addr, mwm_pkg::A_CLEAR) && hwdata[0];

  mwm_compare u_cmp (
    .meas(meas),
    .th_pos(th_pos),
    .th_drv(th_drv),
    .th_mtr(th_mtr),
    .th_ov(th_ov),
    .th_uv(th_uv),
    .th_tlc(th_tlc),
    .th_spd(th_spd),
    .cause(cmp_cause)
  );

  // Codes at or above the source width read as constant off
  always_comb begin
    user_selected_warning_flag = usr_inv;
    if (usr_sel < 8'(SRC_W)) begin
      user_selected_warning_flag = usr_src[usr_sel[6:0]] ^ usr_inv;
    end
  end

  assign cause = {cmp_cause, user_selected_warning_flag};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cause_q <= '0;
    end else begin
      cause_q <= cause;
    end
  end
  assign rise = cause & ~cause_q;

  // Flags: set wins; drop on auto-clear or host clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (cause[i]) flags[i] <= 1'b1;
        else if (auto_clr || clr_cmd) flags[i] <= 1'b0;
      end
    end
  end

  // Summary: only action-enabled conditions feed it
  wire [N-1:0] sum_cause = cause & action;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      summary <= 1'b0;
    end else if (|sum_cause) begin
      summary <= 1'b1;
    end else if (auto_clr || clr_cmd) begin
      summary <= 1'b0;
    end
  end
  assign per_condition_warning_flag = flags;
  assign warning_summary_output = summary;

  assign blink_start = led_en && |(rise & action);
  mwm_led #(.PHASE_CYC(BLINK_CYC)) u_led (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(blink_start),
    .led(power_alarm_led),
    .busy(led_busy)
  );

  // Sticky interrupt status, write one to clear; set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_st <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (rise[i]) irq_st[i] <= 1'b1;
        else if (wr_pend && hit(wr_addr, mwm_pkg::A_IRQST) && hwdata[i]) irq_st[i] <= 1'b0;
      end
    end
  end
  assign irq = |(irq_st & irq_msk);
  // No motor-stop output exists: warnings cannot de-energize the drive.

  a_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
    cause[mwm_pkg::C_POS] |=> flags[mwm_pkg::C_POS]) else $error("flag not set");
  a_flag_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (!auto_clr && !clr_cmd && flags[1]) |=> flags[1]) else $error("latched flag lost");
  a_auto_clr: assert property (@(posedge hclk) disable iff (!hresetn)
    (auto_clr && !cause[2]) |=> !flags[2]) else $error("flag not auto cleared");
  a_sum_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (|(cause & action)) |=> warning_summary_output) else $error("summary missing");
  a_act_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (action == 8'h00 && !summary) |=> !summary) else $error("summary with action 0");
  a_led_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    blink_start |-> led_en) else $error("blink while LED disabled");
  a_usr_off: assert property (@(posedge hclk) disable iff (!hresetn)
    (usr_sel == 8'd128) |-> (user_selected_warning_flag == usr_inv))
    else $error("const off source wrong");
  a_usr_inv: assert property (@(posedge hclk) disable iff (!hresetn)
    (usr_sel < 8'd128) |-> (user_selected_warning_flag != (usr_src[usr_sel[6:0]] == usr_inv)))
    else $error("user flag inversion wrong");
  a_pos_cmp: assert property (@(posedge hclk) disable iff (!hresetn)
    cause[1] == (meas.pos_dev > th_pos)) else $error("position compare wrong");
  a_spd_off: assert property (@(posedge hclk) disable iff (!hresetn)
    (th_spd == 16'h0000) |-> !cause[7]) else $error("speed check not disabled");

  // Blink steps: a start from idle lights both elements two edges later
  sequence s_blink_go;
    blink_start && !led_busy;
  endsequence
  sequence s_lit;
    power_alarm_led.red && power_alarm_led.green;
  endsequence
  a_blink_lit: assert property (@(posedge hclk) disable iff (!hresetn)
    s_blink_go |-> ##2 s_lit) else $error("blink did not light");
  a_led_pair: assert property (@(posedge hclk) disable iff (!hresetn)
    power_alarm_led.red == power_alarm_led.green) else $error("LED colours split");
  a_led_dark: assert property (@(posedge hclk) disable iff (!hresetn)
    !led_busy |=> !power_alarm_led.red) else $error("LED lit while idle");
  a_flag_only: assert property (@(posedge hclk) disable iff (!hresetn)
    (action == 8'h00) |-> !blink_start) else $error("blink with action 0");
  // Summary falls as soon as no enabled cause remains while auto-clear is set
  a_sum_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    (auto_clr && !(|(cause & action))) |=> !summary) else $error("summary kept");
  a_clr_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    (clr_cmd && !cause[1]) |=> !flags[1]) else $error("clear ignored");
  a_usr_set: assert property (@(posedge hclk) disable iff (!hresetn)
    cause[0] |=> flags[0]) else $error("user flag not set");
  a_irq_set: assert property (@(posedge hclk) disable iff (!hresetn)
    rise[1] |=> irq_st[1]) else $error("irq status not set");
  // Comparators checked against plain threshold arithmetic
  a_drv_cmp: assert property (@(posedge hclk) disable iff (!hresetn)
    cause[2] == (meas.drv_temp >= th_drv)) else $error("driver compare wrong");
  a_mtr_cmp: assert property (@(posedge hclk) disable iff (!hresetn)
    cause[3] == (meas.mtr_temp >= th_mtr)) else $error("motor compare wrong");
  a_ov_cmp: assert property (@(posedge hclk) disable iff (!hresetn)
    cause[4] == (meas.bus_volt >= th_ov)) else $error("overvoltage compare wrong");
  a_uv_cmp: assert property (@(posedge hclk) disable iff (!hresetn)
    cause[5] == (meas.bus_volt <= th_uv)) else $error("undervoltage compare wrong");
  a_tlc_off: assert property (@(posedge hclk) disable iff (!hresetn)
    (th_tlc == 16'h0000) |-> !cause[6]) else $error("torque check not disabled");
  a_tlc_cmp: assert property (@(posedge hclk) disable iff (!hresetn)
    (th_tlc != 16'h0000) |-> (cause[6] == (meas.tlc_ms >= th_tlc)))
    else $error("torque compare wrong");
  a_spd_cmp: assert property (@(posedge hclk) disable iff (!hresetn)
    (th_spd != 16'h0000) |-> (cause[7] == (meas.speed >= th_spd)))
    else $error("speed compare wrong");
endmodule : mwm_top
`default_nettype wire

// ### sim/mwm_host.sv
// Host controller model issuing single-word AHB-Lite transfers
`timescale 1ns/100ps
`default_nettype none
module mwm_host (
  // Clock
  input wire logic hclk,
  // Request side
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  // Answer side
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // Bounded wait; a stuck slave ends the run
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 16) begin
        mwm_top_bench.bad_count++;
        mwm_top_bench.end_sim();
      end
      @(posedge hclk);
    end
  endtask : wait_rdy
  // Called just after a rising edge; returns on the data phase edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : ~hwdata;
    wait_rdy();
    q = hrdata;
  endtask : xfer
endmodule : mwm_host
`default_nettype wire

// ### sim/mwm_top_bench.sv
// Self-checking bench for the maintenance warning monitor
`timescale 1ns/100ps
`default_nettype none
module mwm_top_bench;
  localparam logic [7:0] RA [13] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h18, 8'h20, 8'h24,
    8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C};
  localparam logic [31:0] RV [13] = '{32'h0, 32'h3, 32'hFF, 32'h80, 32'h0, 32'h12C,
    32'h55, 32'h55, 32'h190, 32'h78, 32'h0, 32'h0, 32'h0};
  localparam logic [15:0] NON [8] = '{16'h0, 16'h12C, 16'h54, 16'h54, 16'h18F, 16'h79,
    16'h31, 16'h31};
  localparam logic [15:0] TRIP [8] = '{16'h0, 16'h12D, 16'h55, 16'h55, 16'h190, 16'h78,
    16'h32, 16'h32};
  localparam logic [15:0] BASE [8] = '{16'h0, 16'h0, 16'h14, 16'h14, 16'h12C, 16'h12C,
    16'h0, 16'h0};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hready, hresp, irq, summ;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [127:0] usr_src = 128'h0;
  logic [7:0] flags;
  mwm_pkg::mwm_meas_t meas = '{16'h0, 16'h14, 16'h14, 16'h12C, 16'h0, 16'h0};
  mwm_pkg::mwm_led_t led;
  int bad_count = 0;
  int check_count = 0;
  always #50 hclk = ~hclk;
  // Short blink phases keep the run brief
  mwm_top #(.BLINK_CYC(4)) mwm_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .meas(meas),
    .usr_src(usr_src), .per_condition_warning_flag(flags),
    .warning_summary_output(summ), .power_alarm_led(led), .irq(irq));
  mwm_host mwm_host_inst (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge hclk);
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    mwm_host_inst.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    mwm_host_inst.xfer(1'b0, a, 32'h0, q);
    chk("register", q, exp);
  endtask : rchk
  task automatic setm(input int i, input logic [15:0] v);
    case (i)
      1: meas.pos_dev <= v;
      2: meas.drv_temp <= v;
      3: meas.mtr_temp <= v;
      4, 5: meas.bus_volt <= v;
      6: meas.tlc_ms <= v;
      default: meas.speed <= v;
    endcase
  endtask : setm
  // Trips condition i and counts lit phases; red and green must move together
  task automatic blinks(input int i, output int n, output logic [7:0] fl, output logic s);
    logic red_q;
    n = 0;
    red_q = 1'b0;
    fl = 8'h00;
    s = 1'b0;
    setm(i, TRIP[i]);
    for (int k = 0; k < 30; k++) begin
      @(posedge hclk);
      chk("led_pair", 32'(led.red), 32'(led.green));
      if (led.red === 1'b1 && red_q === 1'b0) n++;
      red_q = led.red;
      if (k == 3) begin
        fl = flags;
        s = summ;
      end
    end
    setm(i, BASE[i]);
    step(20);
  endtask : blinks
  task automatic t_defaults;
    for (int i = 0; i < 13; i++) begin
      rchk(RA[i], RV[i]);
    end
    chk("hresp", 32'(hresp), 32'h0);
  endtask : t_defaults
  task automatic t_conditions;
    int n;
    logic [7:0] fl;
    logic s;
    setm(6, TRIP[6]);
    step(1);
    setm(7, TRIP[7]);
    step(3);
    chk("flags_off", 32'(flags), 32'h0);
    setm(6, BASE[6]);
    step(1);
    setm(7, BASE[7]);
    wr(8'h34, 32'h32);
    wr(8'h38, 32'h32);
    for (int i = 1; i < 8; i++) begin
      setm(i, NON[i]);
      step(3);
      chk("flags_near", 32'(flags), 32'h0);
      blinks(i, n, fl, s);
      chk("flag_bit", 32'(fl), 32'h1 << i);
      chk("summary", 32'(s), 32'h1);
      chk("blinks", n, 32'h2);
      chk("flags_gone", 32'(flags), 32'h0);
      chk("summary_gone", 32'(summ), 32'h0);
    end
  endtask : t_conditions
  task automatic t_quiet;
    int n;
    logic [7:0] fl;
    logic s;
    wr(8'h08, 32'hFD);
    blinks(1, n, fl, s);
    chk("flag_only", 32'(fl), 32'h2);
    chk("no_summary", 32'(s), 32'h0);
    chk("no_blink", n, 32'h0);
    wr(8'h08, 32'hFF);
    wr(8'h04, 32'h1);
    blinks(2, n, fl, s);
    chk("led_off", n, 32'h0);
    chk("led_off_summary", 32'(s), 32'h1);
    wr(8'h04, 32'h3);
  endtask : t_quiet
  task automatic t_latch;
    wr(8'h04, 32'h2);
    setm(1, TRIP[1]);
    step(3);
    setm(1, BASE[1]);
    step(3);
    chk("latched_flag", 32'(flags), 32'h2);
    chk("latched_summary", 32'(summ), 32'h1);
    rchk(8'h00, 32'h102);
    wr(8'h10, 32'h1);
    step(2);
    chk("cleared_flag", 32'(flags), 32'h0);
    chk("cleared_summary", 32'(summ), 32'h0);
    wr(8'h04, 32'h3);
    step(20);
  endtask : t_latch
  task automatic t_user;
    usr_src[5] <= 1'b1;
    wr(8'h0C, 32'h5);
    step(3);
    chk("user_follow", 32'(flags), 32'h1);
    wr(8'h04, 32'h103);
    step(3);
    chk("user_invert", 32'(flags), 32'h0);
    usr_src[5] <= 1'b0;
    step(3);
    chk("user_invert_low", 32'(flags), 32'h1);
    wr(8'h0C, 32'h80);
    step(3);
    chk("const_off_inv", 32'(flags), 32'h1);
    wr(8'h04, 32'h3);
    step(3);
    chk("const_off", 32'(flags), 32'h0);
    step(20);
  endtask : t_user
  task automatic t_irq;
    wr(8'h18, 32'h2);
    wr(8'h14, 32'hFF);
    step(2);
    chk("irq_idle", 32'(irq), 32'h0);
    setm(1, TRIP[1]);
    step(3);
    chk("irq_set", 32'(irq), 32'h1);
    setm(1, BASE[1]);
    step(3);
    chk("irq_sticky", 32'(irq), 32'h1);
    wr(8'h14, 32'h2);
    step(2);
    chk("irq_clear", 32'(irq), 32'h0);
    step(20);
  endtask : t_irq
  task automatic t_reset;
    wr(8'h04, 32'h2);
    hresetn <= 1'b0;
    step(2);
    chk("reset_flags", 32'(flags), 32'h0);
    chk("reset_led", 32'(led), 32'h0);
    hresetn <= 1'b1;
    step(1);
    rchk(8'h04, 32'h3);
  endtask : t_reset
  initial begin
    step(10);
    hresetn <= 1'b1;
    step(1);
    t_defaults();
    t_conditions();
    t_quiet();
    t_latch();
    t_user();
    t_irq();
    t_reset();
    end_sim();
  end
  // Run limit: a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge hclk);
    bad_count++;
    end_sim();
  end
endmodule : mwm_top_bench
`default_nettype wire
